/* File: design/gsc_supply_control.v */
// Command interpreter and service request logic for the bus-controlled supply adapter
`timescale 1ns/1ps
`include "gsc_regs.vh"

// Overview of operation
// - Bus address is switch bank positions one to five, binary, range 0 to 31.
// - Switch position six on selects listen-only mode.
// - Switch positions seven and eight are ignored.
// - Address and listen-only switches are sampled once after each reset release.
// - Local key press in remote mode returns supplies to local control.
// - A valid setting command puts the addressed supply into remote mode.
// - Each control port takes two interrupt inputs and drives one output on/off line.
// - An active supply interrupt asserts the service request line.
// - Controller serial-polls; the device answers with its status byte.
// - Status byte is 61h for syntax error, 62h for setting error.
// - Status byte is 64h breaker trip, 68h to constant current, 58h to constant voltage.
// - A supply selection outside the permitted set is rejected and raises a request.
// - Output data before the supply is selected raises a service request.
// - Group execute trigger while addressed switches on the outputs of the selected channels.
// - A command outside the defined format is a syntax error.
// - A setting above the selected supply's range is a setting error.
// - Current data to a voltage channel, or the reverse, is a setting error.
// - Output-on before any supply is selected is a setting error.
// - Four mask commands choose which supply causes may raise requests.
// - Addressed mode: breaker trip reinitialises then requests; others just request.
// - Listen-only: command errors only reinitialise; supply causes are ignored.
module gsc_supply_control #(
  parameter VAL_W = 12
) (
  // APB slave
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output wire              pready,
  output wire              pslverr,
  output reg  [31:0]       prdata,
  // Rear switch bank and front key
  input  wire [7:0]        switch_bank,
  input  wire              local_return_key,
  // Bus interface function front end
  input  wire              bus_listen_addressed,
  input  wire              bus_trigger,
  input  wire              bus_serial_poll,
  output reg               bus_srq,
  output reg  [7:0]        bus_status_byte,
  output reg  [4:0]        bus_address,
  output reg               listen_only,
  // Supply control ports, index 0 is channel A, 1 is channel B
  input  wire [1:0]        supply_breaker_trip,
  input  wire [1:0]        supply_cc_mode,
  output reg  [1:0]        supply_output_on,
  output reg  [1:0]        supply_remote,
  output reg  [VAL_W-1:0]  setpoint_a,
  output reg  [VAL_W-1:0]  setpoint_b
);

  // Synchronisers for every pin input
  reg  [7:0]  sw_s1_reg;
  reg  [7:0]  sw_s2_reg;
  reg  [6:0]  pin_s1_reg;
  reg  [6:0]  pin_s2_reg;
  reg  [6:0]  pin_d_reg;
  reg         sw_taken_reg;

  // The switch synchroniser is not reset: it keeps sampling through reset, so the bank
  // is settled in the second stage when the one-time capture fires after release
  always @(posedge pclk) begin
    sw_s1_reg <= switch_bank;
    sw_s2_reg <= sw_s1_reg;
  end

  // Edges are taken behind the second stage so a metastable first stage never reaches logic
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 7'h00;
      pin_s2_reg <= 7'h00;
      pin_d_reg  <= 7'h00;
    end else begin
      pin_s1_reg <= {local_return_key, bus_listen_addressed, bus_trigger, bus_serial_poll,
                     supply_breaker_trip, supply_cc_mode[0]};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end

  // The cc inputs of both channels need their own bit; channel B rides a separate pair
  reg         ccb_s1_reg;
  reg         ccb_s2_reg;
  reg         ccb_d_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccb_s1_reg <= 1'b0;
      ccb_s2_reg <= 1'b0;
      ccb_d_reg  <= 1'b0;
    end else begin
      ccb_s1_reg <= supply_cc_mode[1];
      ccb_s2_reg <= ccb_s1_reg;
      ccb_d_reg  <= ccb_s2_reg;
    end
  end

  wire       key_rise  = pin_s2_reg[6] & ~pin_d_reg[6];
  wire       addressed = pin_s2_reg[5];
  wire       trig_rise = pin_s2_reg[4] & ~pin_d_reg[4];
  wire       poll_rise = pin_s2_reg[3] & ~pin_d_reg[3];
  wire [1:0] brk_rise  = pin_s2_reg[2:1] & ~pin_d_reg[2:1];
  wire [1:0] cc_now    = {ccb_s2_reg, pin_s2_reg[0]};
  wire [1:0] cc_was    = {ccb_d_reg, pin_d_reg[0]};
  // A falling cc line means the supply went back to constant voltage
  wire [1:0] to_cc     = cc_now & ~cc_was;
  wire [1:0] to_cv     = ~cc_now & cc_was;

  // Switches are caught once, two edges after reset release so the synchroniser has settled
  reg         sw_wait_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_wait_reg  <= 1'b0;
      sw_taken_reg <= 1'b0;
      bus_address  <= 5'h00;
      listen_only  <= 1'b0;
    end else begin
      sw_wait_reg <= 1'b1;
      if (sw_wait_reg && !sw_taken_reg) begin
        sw_taken_reg <= 1'b1;
        bus_address  <= sw_s2_reg[`GSC_SW_ADDR_MSB:0];
        listen_only  <= sw_s2_reg[`GSC_SW_LONLY_BIT];
        // Positions seven and eight are never looked at
      end
    end
  end

  // APB decode; every access completes in its first access cycle
  wire        setup_phase = psel & ~penable;
  wire        access_wr   = psel & penable & pwrite;
  wire        addr_hit    = (paddr == `GSC_CMD_OFS) || (paddr == `GSC_STAT_OFS) ||
                            (paddr == `GSC_SETPT_A_OFS) || (paddr == `GSC_SETPT_B_OFS) ||
                            (paddr == `GSC_MASK_OFS);
  // No wait states: every readable value is a flop or a fixed decode
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // Command word: op in the low nibble, channel in bit 4, value in bits 19 to 8
  wire              cmd_go  = access_wr && (paddr == `GSC_CMD_OFS);
  wire [3:0]        cmd_op  = pwdata[`GSC_CMD_OP_MSB:`GSC_CMD_OP_LSB];
  wire              cmd_ch  = pwdata[`GSC_CMD_CH_BIT];
  wire [VAL_W-1:0]  cmd_val = pwdata[`GSC_CMD_VAL_MSB:`GSC_CMD_VAL_LSB];
  // A select command carries the supply kind in the top two value bits and the limit below
  wire [1:0]        sel_kind  = cmd_val[`GSC_SEL_KIND_MSB:`GSC_SEL_KIND_LSB];
  wire [9:0]        sel_limit = cmd_val[`GSC_SEL_LIM_MSB:`GSC_SEL_LIM_LSB];

  // Per-channel configuration
  reg  [1:0]        selected_reg;
  reg  [1:0]        kind_a_reg;
  reg  [1:0]        kind_b_reg;
  reg  [9:0]        limit_a_reg;
  reg  [9:0]        limit_b_reg;
  reg  [1:0]        mask_a_reg;
  reg  [1:0]        mask_b_reg;

  wire [1:0]        ch_kind  = cmd_ch ? kind_b_reg : kind_a_reg;
  wire [9:0]        ch_limit = cmd_ch ? limit_b_reg : limit_a_reg;
  wire              ch_sel   = cmd_ch ? selected_reg[1] : selected_reg[0];
  // Limit is the top ten bits of the full data range; the low two bits are free
  wire              over     = cmd_val[VAL_W-1:2] > ch_limit;
  wire              is_data  = (cmd_op == `GSC_OP_DATA_V) || (cmd_op == `GSC_OP_DATA_A);
  wire [1:0]        want     = (cmd_op == `GSC_OP_DATA_V) ? `GSC_KIND_VOLT : `GSC_KIND_CURR;

  reg               err_syntax;
  reg               err_setting;
  always @* begin
    err_syntax  = 1'b0;
    err_setting = 1'b0;
    if (cmd_go) begin
      case (cmd_op)
        `GSC_OP_SELECT:
          err_setting = (sel_kind != `GSC_KIND_VOLT) && (sel_kind != `GSC_KIND_CURR);
        `GSC_OP_DATA_V, `GSC_OP_DATA_A:
          err_setting = !ch_sel || (ch_kind != want) || over;
        `GSC_OP_OUT_ON:
          err_setting = !ch_sel;
        `GSC_OP_OUT_OFF, `GSC_OP_MASK_NONE, `GSC_OP_MASK_BRK,
        `GSC_OP_MASK_MODE, `GSC_OP_MASK_ALL:
          err_setting = 1'b0;
        // Opcodes 9 to 15 are undefined
        default:
          err_syntax = 1'b1;
      endcase
    end
  end
  wire cmd_ok = cmd_go && !err_syntax && !err_setting;

  // Supply causes allowed through the per-channel mask
  // Code 0 blocks every cause and 3 passes all; reset is 3 so trips are reported before any mask is set
  function cause_ok;
    input [1:0] mode;
    input       brk;
    begin
      case (mode)
        `GSC_MASK_ALL_CAUSES: cause_ok = 1'b0;
        `GSC_MASK_BRK_ONLY:   cause_ok = brk;
        `GSC_MASK_MODE_ONLY:  cause_ok = !brk;
        default:              cause_ok = 1'b1;
      endcase
    end
  endfunction

  wire brk_a = brk_rise[0] && cause_ok(mask_a_reg, 1'b1);
  wire brk_b = brk_rise[1] && cause_ok(mask_b_reg, 1'b1);
  wire cc_a  = to_cc[0] && cause_ok(mask_a_reg, 1'b0);
  wire cc_b  = to_cc[1] && cause_ok(mask_b_reg, 1'b0);
  wire cv_a  = to_cv[0] && cause_ok(mask_a_reg, 1'b0);
  wire cv_b  = to_cv[1] && cause_ok(mask_b_reg, 1'b0);

  // Cause priority: command errors, then breaker, then mode changes
  reg  [7:0] cause_code;
  reg        cause_hit;
  always @* begin
    cause_hit  = 1'b1;
    cause_code = 8'h00;
    if (err_syntax)
      cause_code = `GSC_SB_SYNTAX;
    else if (err_setting)
      cause_code = `GSC_SB_SETTING;
    else if (!listen_only && (brk_a || brk_b))
      cause_code = `GSC_SB_BREAKER;
    else if (!listen_only && (cc_a || cc_b))
      cause_code = `GSC_SB_TO_CC;
    else if (!listen_only && (cv_a || cv_b))
      cause_code = `GSC_SB_TO_CV;
    else
      cause_hit = 1'b0;
  end

  // Reinitialise on breaker trip when addressed, and on command errors when listen-only
  wire reinit = listen_only ? (err_syntax || err_setting) :
                              (cause_code == `GSC_SB_BREAKER);
  // Listen-only mode never drives the request line
  wire raise  = cause_hit && !listen_only;
  // An accepted command write in the same cycle takes precedence over the trigger
  wire get_on = trig_rise && addressed && !listen_only;

  // Command execution and channel state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      selected_reg     <= 2'b00;
      kind_a_reg       <= 2'b00;
      kind_b_reg       <= 2'b00;
      limit_a_reg      <= 10'h000;
      limit_b_reg      <= 10'h000;
      mask_a_reg       <= `GSC_MASK_RST;
      mask_b_reg       <= `GSC_MASK_RST;
      supply_output_on <= 2'b00;
      supply_remote    <= 2'b00;
      setpoint_a       <= {VAL_W{1'b0}};
      setpoint_b       <= {VAL_W{1'b0}};
    end else if (reinit) begin
      // Masks, limits and a pending request survive, so the controller can still poll the cause
      selected_reg     <= 2'b00;
      supply_output_on <= 2'b00;
      supply_remote    <= 2'b00;
      setpoint_a       <= {VAL_W{1'b0}};
      setpoint_b       <= {VAL_W{1'b0}};
    end else begin
      if (cmd_ok) begin
        case (cmd_op)
          `GSC_OP_SELECT: begin
            selected_reg[cmd_ch] <= 1'b1;
            if (cmd_ch) begin
              kind_b_reg  <= sel_kind;
              limit_b_reg <= sel_limit;
            end else begin
              kind_a_reg  <= sel_kind;
              limit_a_reg <= sel_limit;
            end
          end
          `GSC_OP_DATA_V, `GSC_OP_DATA_A: begin
            supply_remote[cmd_ch] <= 1'b1;
            if (cmd_ch)
              setpoint_b <= cmd_val;
            else
              setpoint_a <= cmd_val;
          end
          `GSC_OP_OUT_ON:
            supply_output_on[cmd_ch] <= 1'b1;
          `GSC_OP_OUT_OFF:
            supply_output_on[cmd_ch] <= 1'b0;
          default: begin
            if (cmd_ch)
              mask_b_reg <= cmd_op[1:0] - 2'h1;
            else
              mask_a_reg <= cmd_op[1:0] - 2'h1;
          end
        endcase
      end else if (get_on) begin
        supply_output_on <= selected_reg;
      end
      // The key hands both channels back to their own panels
      if (key_rise)
        supply_remote <= 2'b00;
    end
  end

  // While a request waits, later causes are dropped; the controller polls the first one
  // Service request and held status byte; a new cause in the poll cycle wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_srq         <= 1'b0;
      bus_status_byte <= 8'h00;
    end else if (raise && (!bus_srq || poll_rise)) begin
      bus_srq         <= 1'b1;
      bus_status_byte <= cause_code;
    end else if (poll_rise && bus_srq) begin
      bus_srq <= 1'b0;
    end
  end

  // Registered read data, captured in the setup cycle
  // A register that changes in the setup cycle is read with its old value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase && !pwrite) begin
      case (paddr)
        `GSC_STAT_OFS:
          prdata <= {8'h00, supply_output_on, supply_remote, selected_reg, listen_only,
                     bus_srq, bus_address, 3'h0, bus_status_byte};
        `GSC_SETPT_A_OFS:
          prdata <= {{(32-VAL_W){1'b0}}, setpoint_a};
        `GSC_SETPT_B_OFS:
          prdata <= {{(32-VAL_W){1'b0}}, setpoint_b};
        `GSC_MASK_OFS:
          prdata <= {28'h0000000, mask_b_reg, mask_a_reg};
        default:
          prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

/* File: common/gsc_regs.vh */
// Register map, field layout, codes and reset values of the supply control block
`ifndef GSC_REGS_VH
`define GSC_REGS_VH

// APB byte offsets
`define GSC_CMD_OFS        8'h00
`define GSC_STAT_OFS       8'h04
`define GSC_SETPT_A_OFS    8'h08
`define GSC_SETPT_B_OFS    8'h0C
`define GSC_MASK_OFS       8'h10

// Command word fields
`define GSC_CMD_OP_MSB     3
`define GSC_CMD_OP_LSB     0
`define GSC_CMD_CH_BIT     4
`define GSC_CMD_VAL_MSB    19
`define GSC_CMD_VAL_LSB    8
`define GSC_SEL_KIND_MSB   11
`define GSC_SEL_KIND_LSB   10
`define GSC_SEL_LIM_MSB    9
`define GSC_SEL_LIM_LSB    0

// Command opcodes
`define GSC_OP_SELECT      4'h0
`define GSC_OP_DATA_V      4'h1
`define GSC_OP_DATA_A      4'h2
`define GSC_OP_OUT_ON      4'h3
`define GSC_OP_OUT_OFF     4'h4
`define GSC_OP_MASK_NONE   4'h5
`define GSC_OP_MASK_BRK    4'h6
`define GSC_OP_MASK_MODE   4'h7
`define GSC_OP_MASK_ALL    4'h8

// Supply kinds in a select command
`define GSC_KIND_VOLT      2'h1
`define GSC_KIND_CURR      2'h2

// Mask modes per channel
`define GSC_MASK_ALL_CAUSES 2'h0
`define GSC_MASK_BRK_ONLY   2'h1
`define GSC_MASK_MODE_ONLY  2'h2
`define GSC_MASK_NONE       2'h3
`define GSC_MASK_RST        2'h3

// Status byte codes
`define GSC_SB_SYNTAX      8'h61
`define GSC_SB_SETTING     8'h62
`define GSC_SB_BREAKER     8'h64
`define GSC_SB_TO_CC       8'h68
`define GSC_SB_TO_CV       8'h58

// Switch bank fields
`define GSC_SW_ADDR_MSB    4
`define GSC_SW_LONLY_BIT   5

`endif

/* File: sim/gsc_supply_control_asserts.sv */
// Port-level checker for the supply control block
`timescale 1ns/1ps
module gsc_supply_control_asserts #(
  parameter VAL_W = 12
) (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  // Switches, key and bus front end
  input wire logic [7:0] switch_bank,
  input wire logic       local_return_key,
  input wire logic       bus_trigger,
  input wire logic       bus_serial_poll,
  input wire logic       bus_srq,
  input wire logic [7:0] bus_status_byte,
  input wire logic [4:0] bus_address,
  input wire logic       listen_only,
  // Supply control
  input wire logic [1:0] supply_output_on,
  input wire logic [1:0] supply_remote
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Edges since reset release, saturating so the capture window is seen once
  logic [2:0] rcnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) rcnt <= 3'h0;
    else if (rcnt != 3'h7) rcnt <= rcnt + 3'h1;
  end
  addr_capture_a: assert property (rcnt == 3'h4 |->
    bus_address == switch_bank[4:0] && listen_only == switch_bank[5]) else $error("switch capture wrong");
  switch_hold_a: assert property (rcnt == 3'h7 |->
    $stable(bus_address) && $stable(listen_only)) else $error("switch setting changed after capture");
  srq_lonly_a: assert property (listen_only |-> !bus_srq) else $error("request in listen-only");
  srq_code_a: assert property ($rose(bus_srq) |->
    bus_status_byte inside {8'h61, 8'h62, 8'h64, 8'h68, 8'h58}) else $error("bad status code");
  srq_release_a: assert property ($fell(bus_srq) |->
    $past(bus_serial_poll, 3) || $past(bus_serial_poll, 4) || $past(bus_serial_poll, 5))
    else $error("request dropped without poll");
  remote_cause_a: assert property (|(supply_remote & ~$past(supply_remote)) |->
    $past(psel && penable && pwrite && paddr == 8'h00)) else $error("remote set without command");
  outon_cause_a: assert property (|(supply_output_on & ~$past(supply_output_on)) |->
    $past(psel && penable && pwrite && paddr == 8'h00) || $past(bus_trigger, 2) || $past(bus_trigger, 3)
    || $past(bus_trigger, 4) || $past(bus_trigger, 5)) else $error("output on without cause");
  local_key_a: assert property ($rose(local_return_key) |-> ##[2:8] (supply_remote == 2'h0))
    else $error("local key ignored");
  brk_reinit_a: assert property ($rose(bus_srq) && bus_status_byte == 8'h64 |->
    ##[0:1] (supply_output_on == 2'h0 && supply_remote == 2'h0)) else $error("no reinit on breaker");
  apb_err_a: assert property (psel && penable |->
    pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})) else $error("bad slave error");
endmodule

bind gsc_supply_control gsc_supply_control_asserts #(.VAL_W(VAL_W)) u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pslverr, .switch_bank, .local_return_key, .bus_trigger, .bus_serial_poll, .bus_srq,
  .bus_status_byte, .bus_address, .listen_only, .supply_output_on, .supply_remote);

/* File: sim/gsc_supply_model.sv */
// Behavioural model of the two controlled supplies
`timescale 1ns/1ps
module gsc_supply_model (
  // Clock
  input  wire logic       pclk,
  // Interrupt pair per control port
  output logic      [1:0] supply_breaker_trip,
  output logic      [1:0] supply_cc_mode
);
  initial begin
    supply_breaker_trip = 2'h0;
    supply_cc_mode = 2'h0;
  end
  // Lines move just after an edge; a supply is not synchronous to us, the block syncs them
  task trip(input int ch, input logic v);
    @(posedge pclk);
    supply_breaker_trip[ch] <= v;
  endtask
  task set_cc(input int ch, input logic v);
    @(posedge pclk);
    supply_cc_mode[ch] <= v;
  endtask
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the supply control block
`timescale 1ns/1ps
`include "gsc_regs.vh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, switch_bank, bus_status_byte;
  logic [31:0] pwdata, prdata, rd;
  logic        local_return_key, bus_listen_addressed, bus_trigger, bus_serial_poll, bus_srq, listen_only;
  logic [4:0]  bus_address;
  logic [1:0]  supply_breaker_trip, supply_cc_mode, supply_output_on, supply_remote;
  logic [11:0] setpoint_a, setpoint_b;
  int          miscompares, compares;

  gsc_supply_control #(.VAL_W(12)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .switch_bank, .local_return_key, .bus_listen_addressed, .bus_trigger, .bus_serial_poll,
    .bus_srq, .bus_status_byte, .bus_address, .listen_only, .supply_breaker_trip, .supply_cc_mode,
    .supply_output_on, .supply_remote, .setpoint_a, .setpoint_b);
  gsc_supply_model psm (.pclk, .supply_breaker_trip, .supply_cc_mode);

  initial begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end

  task end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  // Setup, then access held until pready is seen high at an edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task cmd(input logic [3:0] op, input logic ch, input logic [11:0] v);
    apb(1'b1, `GSC_CMD_OFS, {12'h000, v, 3'h0, ch, op});
  endtask

  task expect_srq(input logic [7:0] code);
    int i;
    i = 0;
    while (bus_srq !== 1'b1 && i < 12) begin
      settle(1);
      i++;
    end
    chk("srq", 1, bus_srq);
    chk("status", code, bus_status_byte);
    @(posedge pclk);
    bus_serial_poll <= 1'b1;
    settle(6);
    chk("srq_release", 0, bus_srq);
    chk("status_held", code, bus_status_byte);
    @(posedge pclk);
    bus_serial_poll <= 1'b0;
  endtask

  task no_srq;
    settle(12);
    chk("no_srq", 0, bus_srq);
  endtask

  task t_switch;
    chk("addr", 5'h15, bus_address);
    chk("lonly", 0, listen_only);
    @(posedge pclk);
    switch_bank <= 8'h2A;
    settle(8);
    chk("addr_hold", 5'h15, bus_address);
    apb(1'b0, `GSC_STAT_OFS, 32'h0);
    chk("stat_addr", 5'h15, rd[15:11]);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, rd);
  endtask

  task t_errors;
    cmd(4'h9, 1'b0, 12'h000);
    expect_srq(8'h61);
    cmd(`GSC_OP_DATA_V, 1'b0, 12'h010);
    expect_srq(8'h62);
    cmd(`GSC_OP_OUT_ON, 1'b0, 12'h000);
    expect_srq(8'h62);
    cmd(`GSC_OP_SELECT, 1'b0, 12'hC10);
    expect_srq(8'h62);
  endtask

  task t_setpoint;
    cmd(`GSC_OP_SELECT, 1'b0, {`GSC_KIND_VOLT, 10'h100});
    cmd(`GSC_OP_DATA_V, 1'b0, 12'h403);
    settle(1);
    chk("setpoint_a", 12'h403, setpoint_a);
    chk("remote", 2'h1, supply_remote);
    apb(1'b0, `GSC_SETPT_A_OFS, 32'h0);
    chk("setpt_a_rd", 12'h403, rd);
    cmd(`GSC_OP_DATA_A, 1'b0, 12'h004);
    expect_srq(8'h62);
    cmd(`GSC_OP_DATA_V, 1'b0, 12'h404);
    expect_srq(8'h62);
    chk("setpoint_keep", 12'h403, setpoint_a);
    @(posedge pclk);
    local_return_key <= 1'b1;
    settle(6);
    chk("remote_local", 2'h0, supply_remote);
    @(posedge pclk);
    local_return_key <= 1'b0;
  endtask

  task t_get;
    cmd(`GSC_OP_SELECT, 1'b1, {`GSC_KIND_CURR, 10'h3FF});
    cmd(`GSC_OP_DATA_A, 1'b1, 12'h123);
    settle(1);
    chk("setpoint_b", 12'h123, setpoint_b);
    chk("remote_b", 2'h2, supply_remote);
    apb(1'b0, `GSC_SETPT_B_OFS, 32'h0);
    chk("setpt_b_rd", 12'h123, rd);
    @(posedge pclk);
    bus_listen_addressed <= 1'b1;
    bus_trigger <= 1'b1;
    settle(6);
    chk("get_on", 2'h3, supply_output_on);
    @(posedge pclk);
    bus_trigger <= 1'b0;
    cmd(`GSC_OP_OUT_OFF, 1'b0, 12'h000);
    settle(1);
    chk("out_off", 2'h2, supply_output_on);
  endtask

  task t_supply;
    cmd(`GSC_OP_MASK_NONE, 1'b0, 12'h000);
    psm.set_cc(0, 1'b1);
    no_srq();
    cmd(`GSC_OP_MASK_ALL, 1'b0, 12'h000);
    psm.set_cc(0, 1'b0);
    expect_srq(8'h58);
    psm.set_cc(0, 1'b1);
    expect_srq(8'h68);
    cmd(`GSC_OP_MASK_BRK, 1'b0, 12'h000);
    psm.set_cc(0, 1'b0);
    no_srq();
    cmd(`GSC_OP_MASK_MODE, 1'b0, 12'h000);
    psm.trip(0, 1'b1);
    no_srq();
    psm.trip(0, 1'b0);
    cmd(`GSC_OP_MASK_BRK, 1'b0, 12'h000);
    apb(1'b0, `GSC_MASK_OFS, 32'h0);
    chk("mask_rd", {`GSC_MASK_RST, `GSC_MASK_BRK_ONLY}, rd);
    psm.trip(0, 1'b1);
    expect_srq(8'h64);
    chk("reinit_on", 2'h0, supply_output_on);
    chk("reinit_remote", 2'h0, supply_remote);
    psm.trip(0, 1'b0);
  endtask

  task t_lonly;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    settle(4);
    chk("lonly_set", 1, listen_only);
    chk("addr_new", 5'h0A, bus_address);
    cmd(`GSC_OP_SELECT, 1'b0, {`GSC_KIND_VOLT, 10'h3FF});
    cmd(`GSC_OP_OUT_ON, 1'b0, 12'h000);
    settle(1);
    chk("lonly_on", 2'h1, supply_output_on);
    cmd(4'hF, 1'b0, 12'h000);
    no_srq();
    chk("lonly_reinit", 2'h0, supply_output_on);
    psm.trip(1, 1'b1);
    no_srq();
  endtask

  initial begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    switch_bank = 8'hD5;
    local_return_key = 0;
    bus_listen_addressed = 0;
    bus_trigger = 0;
    bus_serial_poll = 0;
    miscompares = 0;
    compares = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_switch();
    t_errors();
    t_setpoint();
    t_get();
    t_supply();
    t_lonly();
    end_sim();
  end

  // The sequence needs well under 2000 cycles
  initial begin
    #20000;
    miscompares++;
    end_sim();
  end
endmodule
